// ===== hdl/tpw_consts.svh
`ifndef TPW_CONSTS_SVH
`define TPW_CONSTS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define TPW_OFS_TSC 5'h00
`define TPW_OFS_CNT 5'h04
`define TPW_OFS_MOD 5'h08
`define TPW_OFS_SC0 5'h0c
`define TPW_OFS_CV0 5'h10
`define TPW_OFS_SC1 5'h14
`define TPW_OFS_CV1 5'h18

// ****************************************
// field positions
// ****************************************
`define TPW_B_FLAG 7
`define TPW_B_IRQEN 6
`define TPW_B_HALT 5
`define TPW_B_CRST 4
`define TPW_B_LINK 5
`define TPW_B_CCSEL 4
`define TPW_B_ELS_HI 3
`define TPW_B_ELS_LO 2
`define TPW_B_TOV 1
`define TPW_B_MAXD 0

// ****************************************
// reset values and codes
// ****************************************
`define TPW_RST_MOD 16'hffff
`define TPW_RST_HALT 1'b1
`define TPW_PS_EXT 3'h7
`define TPW_PS_MAXDIV 3'h6
`define TPW_PMASK_ALL 6'h3f
`endif

// ===== hdl/tpw_pkg.sv
package tpw_pkg;
    typedef struct packed {
        logic irq_en;
        logic link;
        logic cc_sel;
        logic [1:0] els;
        logic tov;
        logic maxd;
    } tpw_chctl_s;

    typedef enum logic [1:0] {
        TPW_CM_OFF,
        TPW_CM_CAPTURE,
        TPW_CM_COMPARE
    } tpw_chmode_e;

    typedef struct packed {
        logic out;
        logic oe;
    } tpw_pin_s;
endpackage : tpw_pkg

// ===== hdl/tpw_timer.sv
`timescale 1ns/10ps
`include "tpw_consts.svh"
module tpw_timer (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic wait_mode,
    input wire logic stop_mode,
    input wire logic break_active,
    input wire logic break_clear_enable,
    input wire logic external_count_clock_pin,
    input wire logic channel0_pin_in,
    input wire logic channel1_pin_in,
    output tpw_pkg::tpw_pin_s channel0_pin,
    output tpw_pkg::tpw_pin_s channel1_pin,
    output logic ext_clock_forced_input,
    output logic cpu_irq
);
    import tpw_pkg::*;

    // ****************************************
    // state
    // ****************************************
    logic halt_r;
    logic rollover_irq_enable_r;
    logic [2:0] ps_r;
    logic [15:0] mod_r;
    logic [15:0] cnt_r;
    logic [5:0] pre_r;
    tpw_chctl_s chc_r [2];
    logic [15:0] chv_r [2];
    logic [2:0] flag_r;
    logic [2:0] arm_r;
    logic [1:0] out_r;
    logic act_r;
    logic last_r;
    logic ack_r;
    logic [31:0] rdata_r;
    logic [2:0] xs_r;
    logic [2:0] c0s_r;
    logic [2:0] c1s_r;

    // ****************************************
    // register bus
    // ****************************************
    // wait mode stalls the bus rather than failing it, so no access is lost
    wire req = avs_read | avs_write;
    wire go = req & ~ack_r & ~wait_mode;
    wire acc = ack_r & ~wait_mode;
    wire wr = acc & avs_write;
    wire rd_lat = go & avs_read;
    wire [15:0] bm = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wire [15:0] wd = avs_writedata[15:0];
    wire link = chc_r[0].link;
    wire hit_tsc = avs_address == `TPW_OFS_TSC;
    wire hit_cnt = avs_address == `TPW_OFS_CNT;
    wire hit_mod = avs_address == `TPW_OFS_MOD;
    wire hit_sc0 = avs_address == `TPW_OFS_SC0;
    wire hit_cv0 = avs_address == `TPW_OFS_CV0;
    wire hit_sc1 = (avs_address == `TPW_OFS_SC1) & ~link;
    wire hit_cv1 = avs_address == `TPW_OFS_CV1;
    wire lo_en = avs_byteenable[0];
    wire [7:0] tsc_rd = {flag_r[0], rollover_irq_enable_r, halt_r, 1'b0, 1'b0, ps_r};
    wire [7:0] sc0_rd = {flag_r[1], chc_r[0].irq_en, chc_r[0].link, chc_r[0].cc_sel,
                         chc_r[0].els, chc_r[0].tov, chc_r[0].maxd};
    wire [7:0] sc1_rd = {flag_r[2], chc_r[1].irq_en, 1'b0, chc_r[1].cc_sel,
                         chc_r[1].els, chc_r[1].tov, chc_r[1].maxd};
    wire [15:0] rd_mux = hit_tsc ? {8'h00, tsc_rd} :
                         hit_cnt ? cnt_r :
                         hit_mod ? mod_r :
                         hit_sc0 ? {8'h00, sc0_rd} :
                         hit_cv0 ? chv_r[0] :
                         hit_sc1 ? {8'h00, sc1_rd} :
                         hit_cv1 ? chv_r[1] : 16'h0000;
    assign avs_waitrequest = req & ~acc;
    assign avs_readdata = rdata_r;

    // ****************************************
    // counter clock source
    // ****************************************
    wire halted = halt_r | stop_mode | break_active;
    wire crst = wr & hit_tsc & lo_en & wd[`TPW_B_CRST];
    wire ext_sel = ps_r == `TPW_PS_EXT;
    wire ext_rise = xs_r[1] & ~xs_r[2];
    wire [5:0] pmask = `TPW_PMASK_ALL >> (`TPW_PS_MAXDIV - ps_r);
    wire pre_tick = (pre_r & pmask) == pmask;
    wire tick = ~halted & (ext_sel ? ext_rise : pre_tick);
    wire ovf = tick & (cnt_r == mod_r);
    wire [15:0] cnt_nxt = crst ? 16'h0000 :
                          ovf ? 16'h0000 :
                          tick ? cnt_r + 16'h0001 :
                          cnt_r;
    // prescaler keeps its phase while halted, so a resumed count keeps its spacing
    wire [5:0] pre_nxt = crst ? 6'h00 :
                         halted ? pre_r :
                         pre_r + 6'h01;
    assign ext_clock_forced_input = ext_sel;

    // ****************************************
    // linked buffer select
    // ****************************************
    wire cv0_wr = wr & hit_cv0;
    wire cv1_wr = wr & hit_cv1;
    wire last_nxt = ~link ? 1'b0 :
                    cv1_wr ? 1'b1 :
                    cv0_wr ? 1'b0 :
                    last_r;
    wire act_nxt = ~link ? 1'b0 : ovf ? last_r : act_r;
    wire [15:0] cmp_val0 = (link & act_r) ? chv_r[1] : chv_r[0];

    // ****************************************
    // channels
    // ****************************************
    tpw_chmode_e mode [2];
    logic [1:0] cap_evt;
    logic [1:0] cmp_evt;
    logic [1:0] out_nxt;
    logic [2:0] evt;
    wire [1:0] sync_rise = {c1s_r[1] & ~c1s_r[2], c0s_r[1] & ~c0s_r[2]};
    wire [1:0] sync_fall = {~c1s_r[1] & c1s_r[2], ~c0s_r[1] & c0s_r[2]};
    wire allow = ~break_active | break_clear_enable;

    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : g_ch
            wire lk = (i == 0) & chc_r[i].link;
            wire off1 = (i == 1) & link;
            wire els_on = chc_r[i].els != 2'b00;
            wire [15:0] cval = (i == 0) ? cmp_val0 : chv_r[i];
            wire pulse_lvl = ~chc_r[i].els[0];
            wire full = chc_r[i].maxd & chc_r[i].tov;
            wire edge_hit = (chc_r[i].els[0] & sync_rise[i]) | (chc_r[i].els[1] & sync_fall[i]);
            logic o;
            // link first, then capture/compare select
            assign mode[i] = (off1 | ~els_on) ? TPW_CM_OFF :
                             (lk | chc_r[i].cc_sel) ? TPW_CM_COMPARE : TPW_CM_CAPTURE;
            // captures blocked while stopped or in break
            assign cap_evt[i] = (mode[i] == TPW_CM_CAPTURE) & edge_hit & ~halted;
            assign cmp_evt[i] = (mode[i] == TPW_CM_COMPARE) & tick & (cnt_r == cval);
            always_comb begin
                o = out_r[i];
                if ((mode[i] == TPW_CM_COMPARE) & ovf & chc_r[i].tov) begin
                    o = full ? pulse_lvl : ~o;
                end
                // full duty suppresses compares so the level never drops
                if (cmp_evt[i] & ~full) begin
                    unique case (chc_r[i].els)
                        2'b01: o = ~o;
                        2'b10: o = 1'b0;
                        2'b11: o = 1'b1;
                        2'b00: o = out_r[i];
                    endcase
                end
                out_nxt[i] = o;
            end
        end
    endgenerate

    // ****************************************
    // channel pins
    // ****************************************
    assign channel0_pin.out = out_r[0];
    assign channel0_pin.oe = mode[0] == TPW_CM_COMPARE;
    assign channel1_pin.out = out_r[1];
    assign channel1_pin.oe = mode[1] == TPW_CM_COMPARE;

    // ****************************************
    // flags
    // ****************************************
    assign evt = {cap_evt[1] | cmp_evt[1], cap_evt[0] | cmp_evt[0], ovf};
    wire [2:0] own = {hit_sc1, hit_sc0, hit_tsc};
    logic [2:0] flag_nxt;
    logic [2:0] arm_nxt;
    genvar f;
    generate
        for (f = 0; f < 3; f = f + 1) begin : g_flag
            wire rd_arm = rd_lat & own[f] & flag_r[f] & allow;
            wire wr_own = wr & own[f] & lo_en & allow;
            wire clr = wr_own & arm_r[f] & ~wd[`TPW_B_FLAG];
            // a fresh event beats a pending clear
            assign flag_nxt[f] = evt[f] | (flag_r[f] & ~clr);
            assign arm_nxt[f] = evt[f] ? 1'b0 :
                                rd_arm ? 1'b1 :
                                wr_own ? 1'b0 :
                                arm_r[f];
        end
    endgenerate
    wire [2:0] irq_en = {chc_r[1].irq_en & ~link, chc_r[0].irq_en, rollover_irq_enable_r};
    assign cpu_irq = |(flag_r & irq_en);

    // ****************************************
    // register writes
    // ****************************************
    tpw_chctl_s chc_nxt [2];
    logic [15:0] chv_nxt [2];
    wire [15:0] mod_nxt = (wr & hit_mod) ? ((mod_r & ~bm) | (wd & bm)) : mod_r;
    wire tsc_wr = wr & hit_tsc & lo_en;
    wire [1:0] sc_wr = {wr & hit_sc1 & lo_en, wr & hit_sc0 & lo_en};
    wire [1:0] cv_wr = {cv1_wr, cv0_wr};
    generate
        for (i = 0; i < 2; i = i + 1) begin : g_wr
            assign chc_nxt[i] = sc_wr[i] ? tpw_chctl_s'({wd[`TPW_B_IRQEN],
                                (i == 0) & wd[`TPW_B_LINK], wd[`TPW_B_CCSEL],
                                wd[`TPW_B_ELS_HI:`TPW_B_ELS_LO], wd[`TPW_B_TOV],
                                wd[`TPW_B_MAXD]}) : chc_r[i];
            // a capture in the same cycle wins over a software write
            assign chv_nxt[i] = cap_evt[i] ? cnt_r :
                                cv_wr[i] ? ((chv_r[i] & ~bm) | (wd & bm)) : chv_r[i];
        end
    endgenerate

    // ****************************************
    // flip-flops
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            halt_r <= `TPW_RST_HALT;
            rollover_irq_enable_r <= 1'b0;
            ps_r <= 3'h0;
        end else if (tsc_wr) begin
            halt_r <= wd[`TPW_B_HALT];
            rollover_irq_enable_r <= wd[`TPW_B_IRQEN];
            ps_r <= wd[2:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mod_r <= `TPW_RST_MOD;
        end else begin
            mod_r <= mod_nxt;
        end
    end

    // ****************************************
    // counter and prescaler
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 16'h0000;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_r <= 6'h00;
        end else begin
            pre_r <= pre_nxt;
        end
    end

    // ****************************************
    // linked pair selection
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            act_r <= 1'b0;
        end else begin
            act_r <= act_nxt;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_r <= 1'b0;
        end else begin
            last_r <= last_nxt;
        end
    end

    // ****************************************
    // channel state
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chc_r[0] <= '0;
            chc_r[1] <= '0;
        end else begin
            chc_r[0] <= chc_nxt[0];
            chc_r[1] <= chc_nxt[1];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chv_r[0] <= 16'h0000;
            chv_r[1] <= 16'h0000;
        end else begin
            chv_r[0] <= chv_nxt[0];
            chv_r[1] <= chv_nxt[1];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_r <= 2'h0;
        end else begin
            out_r <= out_nxt;
        end
    end

    // ****************************************
    // flag state
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_r <= 3'h0;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            arm_r <= 3'h0;
        end else begin
            arm_r <= arm_nxt;
        end
    end

    // ****************************************
    // bus answer
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= go | (ack_r & wait_mode);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= 32'h0000_0000;
        end else if (rd_lat) begin
            rdata_r <= {16'h0000, rd_mux};
        end
    end

    // ****************************************
    // pin synchronisers
    // ****************************************
    // pins cross in through two flops; the third only feeds edge detection
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            xs_r <= 3'h0;
        end else begin
            xs_r <= {xs_r[1:0], external_count_clock_pin};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            c0s_r <= 3'h0;
        end else begin
            c0s_r <= {c0s_r[1:0], channel0_pin_in};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            c1s_r <= 3'h0;
        end else begin
            c1s_r <= {c1s_r[1:0], channel1_pin_in};
        end
    end
endmodule : tpw_timer

// ===== verif/tpw_pins.sv
`timescale 1ns/10ps
// ****
// pin side model
// ****
module tpw_pins (
    input wire logic clk,
    input wire logic run,
    input wire logic cap,
    input wire tpw_pkg::tpw_pin_s p0,
    input wire tpw_pkg::tpw_pin_s p1,
    output logic ext_pin,
    output logic in0,
    output logic in1
);
    import tpw_pkg::*;
    logic [3:0] ph_r = 4'h0;
    initial ext_pin = 1'b0;
    // half period 13 cycles, under 4 MHz and bus/2; holds still when idle
    always @(posedge clk) begin
        if (run) begin
            ph_r <= (ph_r == 4'hc) ? 4'h0 : ph_r + 4'h1;
            ext_pin <= (ph_r == 4'hc) ? ~ext_pin : ext_pin;
        end
    end
    assign in0 = p0.oe ? p0.out : ~cap;
    assign in1 = p1.oe ? p1.out : cap;
endmodule : tpw_pins

// ===== verif/tpw_props.sv
`timescale 1ns/10ps
// ****
// port checks
// ****
module tpw_props (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic wait_mode,
    input wire logic stop_mode,
    input wire logic break_active,
    input wire logic break_clear_enable,
    input wire tpw_pkg::tpw_pin_s channel0_pin,
    input wire tpw_pkg::tpw_pin_s channel1_pin,
    input wire logic ext_clock_forced_input,
    input wire logic cpu_irq
);
    import tpw_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire req = avs_read || avs_write;
    wire busy = req && !wait_mode;
    chk_wait_stall: assert property (wait_mode && req |-> avs_waitrequest)
        else $error("bus answered in wait mode");
    chk_bus_answer: assert property (busy && avs_waitrequest |=> !avs_waitrequest || !busy)
        else $error("bus answer late");
    // two quiet cycles: a write or a tick already in flight may still land
    chk_stop_freeze: assert property (stop_mode && $past(stop_mode, 2) && !$past(avs_write)
        && !$past(avs_write, 2) |-> $stable(channel0_pin.out) && $stable(cpu_irq))
        else $error("timer moved in stop");
    chk_break_out: assert property (break_active && $past(break_active, 2) && !$past(avs_write)
        && !$past(avs_write, 2) |-> $stable(channel0_pin.out))
        else $error("output moved in break");
    chk_break_flags: assert property ($past(break_active && !break_clear_enable && cpu_irq && !avs_write)
        |-> cpu_irq)
        else $error("flag lost in break");
    chk_ext_input: assert property ($changed(ext_clock_forced_input) |-> $past(avs_write))
        else $error("pin direction changed alone");
    chk_pin_dir: assert property ($changed(channel0_pin.oe) || $changed(channel1_pin.oe)
        |-> $past(avs_write))
        else $error("channel enable changed alone");
    chk_reset_quiet: assert property ($rose(rst_n) |-> !cpu_irq && !channel0_pin.oe && !channel1_pin.oe)
        else $error("outputs active after reset");
endmodule : tpw_props

bind tpw_timer tpw_props tpw_props_i (.clk(clk), .rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .wait_mode(wait_mode), .stop_mode(stop_mode), .break_active(break_active),
    .break_clear_enable(break_clear_enable), .channel0_pin(channel0_pin), .channel1_pin(channel1_pin),
    .ext_clock_forced_input(ext_clock_forced_input), .cpu_irq(cpu_irq));

// ===== verif/tpw_timer_test.sv
`timescale 1ns/10ps
// ****
// register level tests
// ****
module tpw_timer_test;
    import tpw_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0;
    logic wm = 1'b0, sm = 1'b0, brk = 1'b0, bce = 1'b0, run = 1'b0, cap = 1'b0;
    logic [4:0] adr = 5'h00;
    logic [31:0] wd = 32'h0, rdata, v;
    logic wrq, ext, in0, in1, fin, irq;
    tpw_pin_s p0, p1;
    int errors = 0, comparisons = 0, h, h1, h2;
    initial forever #5 clk = ~clk;
    tpw_timer tpw_timer_i (.clk(clk), .rst_n(rst_n), .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wd), .avs_byteenable(4'h3), .avs_readdata(rdata), .avs_waitrequest(wrq),
        .wait_mode(wm), .stop_mode(sm), .break_active(brk), .break_clear_enable(bce),
        .external_count_clock_pin(ext), .channel0_pin_in(in0), .channel1_pin_in(in1),
        .channel0_pin(p0), .channel1_pin(p1), .ext_clock_forced_input(fin), .cpu_irq(irq));
    tpw_pins tpw_pins_i (.clk(clk), .run(run), .cap(cap), .p0(p0), .p1(p1), .ext_pin(ext), .in0(in0), .in1(in1));
    task automatic end_of_test;
        $display("mismatches %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // one idle edge first, so a strobe is never reassigned in one step
    task automatic bus(input logic [4:0] ad, input logic [31:0] d, input logic w = 1'b1);
        int k;
        k = 0;
        @(posedge clk);
        adr <= ad;
        wd <= d;
        rd <= !w;
        wr <= w;
        do begin
            @(posedge clk);
            k++;
        end while (wrq !== 1'b0 && k < 300);
        v = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (k >= 300) begin
            errors++;
            end_of_test();
        end
    endtask : bus
    task automatic rchk(input logic [4:0] ad, input logic [31:0] e);
        bus(ad, 32'h0, 1'b0);
        check(v, e);
    endtask : rchk
    // count latches are exactly g cycles apart
    task automatic gap(input int g, input logic [31:0] e);
        logic [31:0] a;
        bus(5'h04, 32'h0, 1'b0);
        a = v;
        repeat (g - 3) @(posedge clk);
        bus(5'h04, 32'h0, 1'b0);
        check(v - a, e);
    endtask : gap
    task automatic flag;
        bus(5'h00, 32'h40);
        repeat (40) @(posedge clk);
        bus(5'h00, 32'h60);
        rchk(5'h00, 32'he0);
    endtask : flag
    task automatic duty(output int n);
        repeat (32) @(posedge clk);
        n = 0;
        repeat (160) begin
            @(posedge clk);
            n += p0.out;
        end
    endtask : duty
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rchk(5'h00, 32'h20);
        rchk(5'h1c, 32'h0);
        run <= 1'b1;
        for (int ps = 0; ps < 8; ps++) begin
            bus(5'h00, 32'h30);
            bus(5'h00, 32'(ps));
            gap(ps == 7 ? 208 : 128, ps == 7 ? 8 : 128 >> ps);
            check(32'(fin), 32'(ps == 7));
        end
        run <= 1'b0;
        $display("clock source test done");
        bus(5'h00, 32'h0);
        sm <= 1'b1;
        gap(128, 0);
        sm <= 1'b0;
        gap(128, 128);
        brk <= 1'b1;
        gap(128, 0);
        brk <= 1'b0;
        bus(5'h04, 32'h0, 1'b0);
        h = int'(v);
        wm <= 1'b1;
        fork
            bus(5'h04, 32'h0, 1'b0);
            begin
                repeat (40) @(posedge clk);
                wm <= 1'b0;
            end
        join
        check(32'(v >= h + 40), 32'h1);
        $display("low power test done");
        bus(5'h00, 32'h30);
        bus(5'h08, 32'hf);
        flag();
        check(32'(irq), 32'h1);
        bus(5'h00, 32'h60);
        rchk(5'h00, 32'h60);
        flag();
        brk <= 1'b1;
        bus(5'h00, 32'h60);
        rchk(5'h00, 32'he0);
        brk <= 1'b0;
        bus(5'h00, 32'h60);
        rchk(5'h00, 32'h60);
        flag();
        bus(5'h00, 32'he0);
        brk <= 1'b1;
        bce <= 1'b1;
        rchk(5'h00, 32'he0);
        bus(5'h00, 32'h60);
        rchk(5'h00, 32'h60);
        brk <= 1'b0;
        bce <= 1'b0;
        $display("flag test done");
        bus(5'h00, 32'h30);
        bus(5'h10, 32'h4);
        bus(5'h0c, 32'h1a);
        bus(5'h00, 32'h0);
        duty(h1);
        check(32'(p0.oe), 32'h1);
        bus(5'h10, 32'h8);
        duty(h2);
        check(32'(h2 - h1), 32'd40);
        bus(5'h0c, 32'h1e);
        duty(h);
        check(32'(h), 32'(160 - h2));
        bus(5'h0c, 32'h18);
        duty(h);
        check(32'(h), 32'h0);
        bus(5'h0c, 32'h1b);
        duty(h);
        check(32'(h), 32'd160);
        for (int m = 0; m < 2; m++) begin
            bus(5'h10, 32'h4);
            bus(5'h0c, m ? 32'h3a : 32'h2a);
            duty(h);
            check(32'(h), 32'(h1));
            bus(5'h18, 32'h8);
            duty(h);
            check(32'(h), 32'(h2));
        end
        bus(5'h14, 32'h18);
        rchk(5'h14, 32'h0);
        check(32'(p1.oe), 32'h0);
        $display("pwm test done");
        bus(5'h0c, 32'h0);
        bus(5'h14, 32'h44);
        brk <= 1'b1;
        cap <= 1'b1;
        repeat (8) @(posedge clk);
        rchk(5'h14, 32'h44);
        brk <= 1'b0;
        cap <= 1'b0;
        repeat (8) @(posedge clk);
        cap <= 1'b1;
        repeat (8) @(posedge clk);
        rchk(5'h14, 32'hc4);
        check(32'(irq), 32'h1);
        $display("capture test done");
        end_of_test();
    end
endmodule : tpw_timer_test
